// File: hdl/lmr_pkg.sv
// Purpose: shared constants for the mode register link and its two ends
// Assumes: 8-bit mode registers, 8-bit register address on the command link
// Notes: controller registers are 32-bit words on APB
package lmr_pkg;
  // mode register addresses
  localparam logic [7:0] MA_DEVICE_INFO_STATUS = 8'h00;
  localparam logic [7:0] MA_BURST_WRITE_CONFIG = 8'h01;
  // device info fields
  localparam int INFO_AUTO_INIT_PENDING = 0;
  localparam int INFO_DEVICE_KIND_BIT = 1;
  localparam int INFO_SELFTEST_LSB = 3;
  localparam logic [7:0] INFO_RESERVED_MASK = 8'hE4;
  // burst config fields and defaults
  localparam int BWC_LENGTH_LSB = 0;
  localparam int BWC_ORDER_BIT = 3;
  localparam int BWC_WRAP_BIT = 4;
  localparam int BWC_RECOVERY_LSB = 5;
  localparam logic [7:0] BWC_RESET = 8'h22;
  localparam logic [2:0] BL_FOUR = 3'b010;
  localparam logic [2:0] BL_EIGHT = 3'b011;
  localparam logic [2:0] BL_SIXTEEN = 3'b100;
  localparam logic [2:0] WR_CODE_MIN = 3'b001;
  localparam logic [2:0] WR_CODE_MAX = 3'b110;
  localparam logic [3:0] WR_CODE_OFFSET = 4'h2;
  // impedance self-test result codes
  localparam logic [1:0] ZQ_UNSUPPORTED = 2'b00;
  localparam logic [1:0] ZQ_TO_SUPPLY = 2'b01;
  localparam logic [1:0] ZQ_TO_GROUND = 2'b10;
  localparam logic [1:0] ZQ_RESISTOR_OK = 2'b11;
  // controller register offsets and fields
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_BURST = 12'h008;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int CMD_ZQ_BIT = 17;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_REFUSED_BIT = 1;
  localparam int STS_INIT_DONE_BIT = 2;
  localparam int STS_STROBE_BIT = 3;
  localparam int STS_RDATA_LSB = 8;
  localparam int BURST_COL_LSB = 1;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  // burst column for beat n of a burst starting at col
  function automatic logic [3:0] burstColumn(input logic [3:0] col, input logic [3:0] beat,
                                             input logic [2:0] blSel, input logic order,
                                             input logic noWrap);
    logic [3:0] lenMask;
    logic [3:0] sum;
    lenMask = (blSel == BL_SIXTEEN) ? 4'hF : (blSel == BL_EIGHT) ? 4'h7 : 4'h3;
    sum = col + beat;
    if (noWrap) begin
      burstColumn = sum;
    end else if (order) begin
      burstColumn = (col & ~lenMask) | ((col ^ beat) & lenMask);
    end else begin
      burstColumn = (col & ~lenMask) | (sum & lenMask);
    end
  endfunction
endpackage

// File: hdl/lmr_link_if.sv
// Purpose: command/data link between mode register controller and device
// Assumes: one clock, commands one cycle wide
// Notes: read answer and strobe toggle come one cycle after the read
`timescale 1ns/1ps
interface lmr_link_if (
  input wire logic clk_sys
);
  logic cmdValid;
  logic cmdWrite;
  logic cmdZqInit;
  logic [7:0] cmdAddr;
  logic [7:0] cmdData;
  logic colStart;
  logic [3:1] colAddr;
  logic rdValid;
  logic [7:0] rdData;
  logic dqsToggle;
  logic burstValid;
  logic [3:0] burstCol;
  modport device (
    input cmdValid, cmdWrite, cmdZqInit, cmdAddr, cmdData, colStart, colAddr,
    output rdValid, rdData, dqsToggle, burstValid, burstCol
  );
  modport controller (
    output cmdValid, cmdWrite, cmdZqInit, cmdAddr, cmdData, colStart, colAddr,
    input rdValid, rdData, dqsToggle, burstValid, burstCol
  );
endinterface

// File: hdl/lmr_device.sv
// Purpose: device end: info register, burst config, self-test, burst order
// Assumes: commands from the controller are one-cycle pulses on clk_sys
// Notes: only the info and burst config registers exist; every read except of info gives 0
//
// How it works
// RULE1: controller zeroes reserved bits on writes
// RULE2: reserved bits read back as zero
// RULE3: any register read toggles the strobe
// RULE4: controller never writes reserved registers
// RULE5: writes to read-only register are ignored
// RULE6: bits 4:3 report impedance self-test
// RULE7: self-test result set after init calibration
// RULE8: failed self-test forces factory trim
// RULE9: device kind bit reads zero
// RULE10: bit 0 high while auto-init runs
// RULE11: bits 2:0 select burst length
// RULE12: bit 3 selects sequential or interleaved
// RULE13: bit 4 selects wrap, no-wrap only four
// RULE14: bits 7:5 give recovery three to eight
// RULE15: precharge starts recovery cycles after write
// RULE16: controller avoids sixteen with interleaved
// RULE17: wrap four yields 0123 or 2301
// RULE18: column bit 0 is always zero
// RULE19: no-wrap four gives y to y+3
// RULE20: register read and write carry 8-bit address
// RULE21: burst config resets to documented defaults
// RULE22: controller polls init status before use; controller only records bit 0 from info reads issued over APB
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module lmr_device #(
  parameter bit SELFTEST_SUPPORTED = 1'b1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // link to controller
  lmr_link_if.device link,
  // device-side status
  input wire logic autoInitDone,
  input wire logic [1:0] zqSense,
  input wire logic writeBurstAp,
  output logic useFactoryTrim,
  output logic zqCalRun,
  output logic prechargeStart,
  output logic [2:0] burstLengthSel,
  output logic burstOrderSel,
  output logic wrapControl
);
  // state
  logic [7:0] burstCfg_q, burstCfg_d;
  logic [1:0] zqResult_q, zqResult_d;
  logic initPending_q, initPending_d;
  logic fallback_q, fallback_d;
  logic zqCalRun_q, zqCalRun_d;
  logic rdValid_q, rdValid_d;
  logic [7:0] rdData_q, rdData_d;
  logic dqs_q, dqs_d;
  logic [3:0] apCount_q, apCount_d;
  logic apBusy_q, apBusy_d;
  logic precharge_q, precharge_d;
  logic [3:0] startCol_q, startCol_d;
  logic [3:0] beat_q, beat_d;
  logic bursting_q, bursting_d;
  logic burstValid_q, burstValid_d;
  logic [3:0] burstCol_q, burstCol_d;
  logic [7:0] infoWord;
  logic [3:0] lastBeat;
  logic [3:0] recovery;

  // info word, reserved and kind bits forced low
  always_comb begin
    infoWord = 8'h00; // [RULE2]
    infoWord[lmr_pkg::INFO_AUTO_INIT_PENDING] = initPending_q; // [RULE10]
    infoWord[lmr_pkg::INFO_DEVICE_KIND_BIT] = 1'b0; // [RULE9]
    infoWord[lmr_pkg::INFO_SELFTEST_LSB +: 2] = zqResult_q; // [RULE6]
  end

  // beats per burst and recovery count from the config register
  always_comb begin
    case (burstCfg_q[lmr_pkg::BWC_LENGTH_LSB +: 3])
      lmr_pkg::BL_SIXTEEN: lastBeat = 4'hF;
      lmr_pkg::BL_EIGHT: lastBeat = 4'h7;
      default: lastBeat = 4'h3;
    endcase
    recovery = {1'b0, burstCfg_q[lmr_pkg::BWC_RECOVERY_LSB +: 3]} + lmr_pkg::WR_CODE_OFFSET;
  end

  // register access and self-test
  always_comb begin
    burstCfg_d = burstCfg_q;
    zqResult_d = zqResult_q;
    fallback_d = fallback_q;
    zqCalRun_d = 1'b0;
    initPending_d = ~autoInitDone; // [RULE10]
    rdValid_d = 1'b0;
    rdData_d = rdData_q;
    dqs_d = dqs_q;
    if (link.cmdValid && link.cmdWrite) begin // [RULE20]
      // writes to the info register fall through untouched
      if (link.cmdAddr == lmr_pkg::MA_BURST_WRITE_CONFIG) begin
        burstCfg_d = link.cmdData; // [RULE11] [RULE12] [RULE13] [RULE14]
      end // [RULE5]
    end else if (link.cmdValid) begin
      rdValid_d = 1'b1;
      dqs_d = ~dqs_q; // [RULE3]
      // write-only and unused registers answer zero
      rdData_d = (link.cmdAddr == lmr_pkg::MA_DEVICE_INFO_STATUS) ? infoWord : 8'h00; // [RULE3]
    end
    if (link.cmdZqInit && !fallback_q) begin // [RULE8]
      zqCalRun_d = 1'b1;
      if (SELFTEST_SUPPORTED) begin
        zqResult_d = zqSense; // [RULE7]
        fallback_d = (zqSense == lmr_pkg::ZQ_TO_SUPPLY) ||
                     (zqSense == lmr_pkg::ZQ_TO_GROUND); // [RULE8]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      burstCfg_q <= lmr_pkg::BWC_RESET; // [RULE21]
      zqResult_q <= lmr_pkg::ZQ_UNSUPPORTED;
      fallback_q <= 1'b0;
      zqCalRun_q <= 1'b0;
      initPending_q <= 1'b1;
      rdValid_q <= 1'b0;
      rdData_q <= 8'h00;
      dqs_q <= 1'b0;
    end else begin
      burstCfg_q <= burstCfg_d;
      zqResult_q <= zqResult_d;
      fallback_q <= fallback_d;
      zqCalRun_q <= zqCalRun_d;
      initPending_q <= initPending_d;
      rdValid_q <= rdValid_d;
      rdData_q <= rdData_d;
      dqs_q <= dqs_d;
    end
  end

  // auto-precharge countdown after a write burst
  always_comb begin
    apCount_d = apCount_q;
    apBusy_d = apBusy_q;
    precharge_d = 1'b0;
    if (writeBurstAp) begin
      apBusy_d = 1'b1;
      apCount_d = recovery - 4'h1; // [RULE15]
    end else if (apBusy_q) begin
      if (apCount_q == 4'h1) begin
        apBusy_d = 1'b0;
        precharge_d = 1'b1; // [RULE15]
      end
      apCount_d = apCount_q - 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      apCount_q <= 4'h0;
      apBusy_q <= 1'b0;
      precharge_q <= 1'b0;
    end else begin
      apCount_q <= apCount_d;
      apBusy_q <= apBusy_d;
      precharge_q <= precharge_d;
    end
  end

  // burst column sequencer; a new start restarts the sequence
  always_comb begin
    startCol_d = startCol_q;
    beat_d = beat_q;
    bursting_d = bursting_q;
    burstValid_d = 1'b0;
    burstCol_d = burstCol_q;
    if (link.colStart) begin
      startCol_d = {link.colAddr, 1'b0}; // [RULE18]
      beat_d = 4'h0;
      bursting_d = 1'b1;
    end else if (bursting_q) begin
      burstValid_d = 1'b1;
      burstCol_d = lmr_pkg::burstColumn(startCol_q, beat_q,
                     burstCfg_q[lmr_pkg::BWC_LENGTH_LSB +: 3],
                     burstCfg_q[lmr_pkg::BWC_ORDER_BIT],
                     burstCfg_q[lmr_pkg::BWC_WRAP_BIT]); // [RULE17] [RULE19]
      beat_d = beat_q + 4'h1;
      if (beat_q == lastBeat) begin
        bursting_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      startCol_q <= 4'h0;
      beat_q <= 4'h0;
      bursting_q <= 1'b0;
      burstValid_q <= 1'b0;
      burstCol_q <= 4'h0;
    end else begin
      startCol_q <= startCol_d;
      beat_q <= beat_d;
      bursting_q <= bursting_d;
      burstValid_q <= burstValid_d;
      burstCol_q <= burstCol_d;
    end
  end

  // outputs straight from flops
  assign link.rdValid = rdValid_q;
  assign link.rdData = rdData_q;
  assign link.dqsToggle = dqs_q;
  assign link.burstValid = burstValid_q;
  assign link.burstCol = burstCol_q;
  assign useFactoryTrim = fallback_q;
  assign zqCalRun = zqCalRun_q;
  assign prechargeStart = precharge_q;
  assign burstLengthSel = burstCfg_q[lmr_pkg::BWC_LENGTH_LSB +: 3];
  assign burstOrderSel = burstCfg_q[lmr_pkg::BWC_ORDER_BIT];
  assign wrapControl = burstCfg_q[lmr_pkg::BWC_WRAP_BIT];
endmodule

// File: hdl/lmr_controller.sv
// Purpose: controller end: APB registers issue mode register commands
// Assumes: one command in flight; reads wait for the device answer
// Notes: illegal commands are refused here and never reach the link
`timescale 1ns/1ps
module lmr_controller (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to device
  lmr_link_if.controller link
);
  typedef enum logic [1:0] {
    LMR_IDLE = 2'b00,
    LMR_WAIT_READ = 2'b01
  } lmr_state_e;

  lmr_state_e state_q, state_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic cmdValid_q, cmdValid_d;
  logic cmdWrite_q, cmdWrite_d;
  logic zqInit_q, zqInit_d;
  logic [7:0] cmdAddr_q, cmdAddr_d;
  logic [7:0] cmdData_q, cmdData_d;
  logic colStart_q, colStart_d;
  logic [3:1] colAddr_q, colAddr_d;
  logic refused_q, refused_d;
  logic initDone_q, initDone_d;
  logic [7:0] rdByte_q, rdByte_d;
  logic access;
  logic [7:0] newAddr;
  logic [7:0] newData;

  // reserved and do-not-use addresses are never written
  function automatic logic isReservedAddr(input logic [7:0] a);
    isReservedAddr = (a >= 8'h0B && a <= 8'h0F) || (a >= 8'h12 && a <= 8'h1F) ||
                     (a >= 8'h21 && a <= 8'h27) || (a >= 8'h29 && a <= 8'h3E) ||
                     (a >= 8'h40); // [RULE4]
  endfunction

  // burst config values the device cannot serve
  function automatic logic badBurstCfg(input logic [7:0] d);
    logic [2:0] bl;
    logic [2:0] wr;
    bl = d[lmr_pkg::BWC_LENGTH_LSB +: 3];
    wr = d[lmr_pkg::BWC_RECOVERY_LSB +: 3];
    badBurstCfg = !(bl == lmr_pkg::BL_FOUR || bl == lmr_pkg::BL_EIGHT ||
                    bl == lmr_pkg::BL_SIXTEEN) || // [RULE11]
                  (wr < lmr_pkg::WR_CODE_MIN) || (wr > lmr_pkg::WR_CODE_MAX) || // [RULE14]
                  (d[lmr_pkg::BWC_WRAP_BIT] && bl != lmr_pkg::BL_FOUR) || // [RULE13]
                  (d[lmr_pkg::BWC_ORDER_BIT] && bl == lmr_pkg::BL_SIXTEEN); // [RULE16]
  endfunction

  assign access = psel && penable && pready_q;
  assign newAddr = pwdata[7:0];
  assign newData = (newAddr == lmr_pkg::MA_DEVICE_INFO_STATUS) ?
                   (pwdata[lmr_pkg::CMD_DATA_LSB +: 8] & ~lmr_pkg::INFO_RESERVED_MASK) :
                   pwdata[lmr_pkg::CMD_DATA_LSB +: 8]; // [RULE1]

  // apb decode, command issue and read tracking
  always_comb begin
    state_d = state_q;
    pready_d = psel && !penable; // one wait-free access cycle after setup
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    cmdValid_d = 1'b0;
    cmdWrite_d = 1'b0;
    zqInit_d = 1'b0;
    cmdAddr_d = cmdAddr_q;
    cmdData_d = cmdData_q;
    colStart_d = 1'b0;
    colAddr_d = colAddr_q;
    refused_d = refused_q;
    initDone_d = initDone_q;
    rdByte_d = rdByte_q;
    if (psel && !penable && !pwrite) begin
      if (paddr == lmr_pkg::REG_STATUS) begin
        prdata_d[lmr_pkg::STS_BUSY_BIT] = (state_q != LMR_IDLE);
        prdata_d[lmr_pkg::STS_REFUSED_BIT] = refused_q;
        prdata_d[lmr_pkg::STS_INIT_DONE_BIT] = initDone_q; // [RULE22]
        prdata_d[lmr_pkg::STS_STROBE_BIT] = link.dqsToggle;
        prdata_d[lmr_pkg::STS_RDATA_LSB +: 8] = rdByte_q;
      end else if (paddr != lmr_pkg::REG_CMD && paddr != lmr_pkg::REG_BURST) begin
        pslverr_d = 1'b1;
      end
    end else if (psel && !penable) begin
      pslverr_d = !(paddr == lmr_pkg::REG_CMD || paddr == lmr_pkg::REG_BURST);
    end
    if (access && pwrite && paddr == lmr_pkg::REG_CMD) begin
      if (state_q != LMR_IDLE) begin
        refused_d = 1'b1;
      end else if (pwdata[lmr_pkg::CMD_ZQ_BIT]) begin
        zqInit_d = 1'b1;
        refused_d = 1'b0;
      end else if (pwdata[lmr_pkg::CMD_WRITE_BIT] && (isReservedAddr(newAddr) ||
               (newAddr == lmr_pkg::MA_BURST_WRITE_CONFIG && badBurstCfg(newData)))) begin
        refused_d = 1'b1; // [RULE4] [RULE11]
      end else begin
        cmdValid_d = 1'b1; // [RULE20]
        cmdWrite_d = pwdata[lmr_pkg::CMD_WRITE_BIT];
        cmdAddr_d = newAddr;
        cmdData_d = newData;
        refused_d = 1'b0;
        if (!pwdata[lmr_pkg::CMD_WRITE_BIT]) begin
          state_d = LMR_WAIT_READ;
        end
      end
    end else if (access && pwrite && paddr == lmr_pkg::REG_BURST) begin
      colStart_d = 1'b1;
      colAddr_d = pwdata[lmr_pkg::BURST_COL_LSB +: 3]; // [RULE18]
    end
    case (state_q)
      LMR_WAIT_READ: begin
        if (link.rdValid) begin
          rdByte_d = link.rdData;
          state_d = LMR_IDLE;
          if (cmdAddr_q == lmr_pkg::MA_DEVICE_INFO_STATUS) begin
            initDone_d = !link.rdData[lmr_pkg::INFO_AUTO_INIT_PENDING]; // [RULE22]
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= LMR_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= lmr_pkg::STATUS_RESET;
      cmdValid_q <= 1'b0;
      cmdWrite_q <= 1'b0;
      zqInit_q <= 1'b0;
      cmdAddr_q <= 8'h00;
      cmdData_q <= 8'h00;
      colStart_q <= 1'b0;
      colAddr_q <= 3'b000;
      refused_q <= 1'b0;
      initDone_q <= 1'b0;
      rdByte_q <= 8'h00;
    end else begin
      state_q <= state_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      cmdValid_q <= cmdValid_d;
      cmdWrite_q <= cmdWrite_d;
      zqInit_q <= zqInit_d;
      cmdAddr_q <= cmdAddr_d;
      cmdData_q <= cmdData_d;
      colStart_q <= colStart_d;
      colAddr_q <= colAddr_d;
      refused_q <= refused_d;
      initDone_q <= initDone_d;
      rdByte_q <= rdByte_d;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign link.cmdValid = cmdValid_q;
  assign link.cmdWrite = cmdWrite_q;
  assign link.cmdZqInit = zqInit_q;
  assign link.cmdAddr = cmdAddr_q;
  assign link.cmdData = cmdData_q;
  assign link.colStart = colStart_q;
  assign link.colAddr = colAddr_q;
endmodule

// File: verif/lmr_link_assertions.sv
// Purpose: link checks between the mode register controller and the device
// Assumes: one clock, synchronous active-high reset
// Notes: burst config is shadowed from write commands seen on the link
`timescale 1ns/1ps
module lmr_link_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // controller to device
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic cmdZqInit,
  input wire logic [7:0] cmdAddr,
  input wire logic [7:0] cmdData,
  input wire logic colStart,
  input wire logic [3:1] colAddr,
  // device to controller
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  input wire logic dqsToggle,
  input wire logic burstValid,
  input wire logic [3:0] burstCol
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic startHi_q;
  logic startHi_d;
  logic rd;
  logic wr;
  logic bl4Wrap;
  // command decode and burst mode seen by the device
  assign rd = cmdValid && !cmdWrite;
  assign wr = cmdValid && cmdWrite;
  assign bl4Wrap = (cfg_q[2:0] == lmr_pkg::BL_FOUR) && !cfg_q[4];
  // shadow config; only accepted writes ever reach the link
  always_comb begin
    cfg_d = cfg_q;
    startHi_d = startHi_q;
    if (wr && cmdAddr == lmr_pkg::MA_BURST_WRITE_CONFIG) begin
      cfg_d = cmdData;
    end
    if (colStart) begin
      startHi_d = colAddr[1];
    end
  end
  // shadow registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_q <= lmr_pkg::BWC_RESET;
      startHi_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      startHi_q <= startHi_d;
    end
  end
  a_read_answer: assert property (rd |=> rdValid && dqsToggle != $past(dqsToggle))
    else $error("read not answered with a strobe toggle");
  a_strobe_quiet: assert property (!rd |=> $stable(dqsToggle))
    else $error("strobe moved without a read");
  a_info_reserved: assert property (rdValid && $past(cmdAddr) == 8'h00 |->
    (rdData & lmr_pkg::INFO_RESERVED_MASK) == 8'h00) else $error("info reserved bits set");
  a_kind_bit: assert property (rdValid && $past(cmdAddr) == 8'h00 |->
    !rdData[lmr_pkg::INFO_DEVICE_KIND_BIT]) else $error("device kind bit set");
  a_other_zero: assert property (rdValid && $past(cmdAddr) != 8'h00 |->
    rdData == 8'h00) else $error("undefined read not zero");
  // first beat shows two edges after the start is taken: one to load, one to emit
  a_burst_start: assert property (colStart |-> ##2 burstValid &&
    burstCol == {$past(colAddr, 2), 1'b0}) else $error("burst start column wrong");
  a_burst_min: assert property (colStart |-> ##2 burstValid [*4])
    else $error("burst shorter than four beats");
  a_bl4_order: assert property (colStart && bl4Wrap ##1 !colStart [*2] |->
    burstCol[1:0] == {startHi_q, 1'b0} ##1 burstCol[1:0] == {startHi_q, 1'b1}
    ##1 burstCol[1:0] == {~startHi_q, 1'b0} ##1 burstCol[1:0] == {~startHi_q, 1'b1})
    else $error("wrapped burst of four out of order");
  a_reserved_addr: assert property (wr |-> !(cmdAddr inside {
    [8'h0B:8'h0F], [8'h12:8'h1F], [8'h21:8'h27], [8'h29:8'h3E], [8'h40:8'hFF]}))
    else $error("write to reserved register");
  a_write_zeroes: assert property (wr && cmdAddr == 8'h00 |->
    (cmdData & lmr_pkg::INFO_RESERVED_MASK) == 8'h00) else $error("reserved bits written");
  a_config_legal: assert property (wr && cmdAddr == 8'h01 |->
    cmdData[2:0] inside {3'b010, 3'b011, 3'b100} && cmdData[7:5] inside {[3'b001:3'b110]}
    && (!cmdData[4] || cmdData[2:0] == 3'b010)) else $error("illegal burst config sent");
  a_no_bl16_int: assert property (wr && cmdAddr == 8'h01 |->
    !(cmdData[2:0] == 3'b100 && cmdData[3])) else $error("sixteen interleaved sent");
endmodule

// File: verif/tb.sv
// Purpose: self-checking bench for the mode register link, both ends
// Assumes: APB master waits on pready, 4 ns clock
// Notes: ordinary burst configs run from a table, odd cases after it
`timescale 1ns/1ps
module tb;
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, err, strobe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic autoInitDone, writeBurstAp, useFactoryTrim, zqCalRun, prechargeStart;
  logic [1:0] zqSense;
  logic [2:0] burstLengthSel;
  logic burstOrderSel, wrapControl;
  logic [15:0] got;
  int n_mismatch = 0, samples_checked = 0, cycles = 0, k;
  // table rows: config byte, start column bits 3..1, first four beats
  logic [7:0] cfgTab [7] = '{8'h22, 8'h4A, 8'h72, 8'h83, 8'hAB, 8'hC4, 8'h22};
  logic [2:0] colTab [7] = '{3'h1, 3'h1, 3'h3, 3'h1, 3'h3, 3'h5, 3'h0};
  logic [15:0] expTab [7] = '{16'h2301, 16'h2301, 16'h6789, 16'h2345, 16'h6745, 16'hABCD,
                              16'h0123};
  // refused commands: address then data
  logic [15:0] badTab [4] = '{16'h012C, 16'h0B00, 16'h0133, 16'h0112};
  lmr_link_if link (.clk_sys(clk_sys));
  lmr_device lmr_device_i (.clk_sys(clk_sys), .srst(srst), .link(link),
    .autoInitDone(autoInitDone), .zqSense(zqSense), .writeBurstAp(writeBurstAp),
    .useFactoryTrim(useFactoryTrim), .zqCalRun(zqCalRun), .prechargeStart(prechargeStart),
    .burstLengthSel(burstLengthSel), .burstOrderSel(burstOrderSel), .wrapControl(wrapControl));
  lmr_controller lmr_controller_i (.clk_sys(clk_sys), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  lmr_link_assertions lmr_link_assertions_i (.clk_sys(clk_sys), .srst(srst),
    .cmdValid(link.cmdValid), .cmdWrite(link.cmdWrite), .cmdZqInit(link.cmdZqInit),
    .cmdAddr(link.cmdAddr), .cmdData(link.cmdData), .colStart(link.colStart),
    .colAddr(link.colAddr), .rdValid(link.rdValid), .rdData(link.rdData),
    .dqsToggle(link.dqsToggle), .burstValid(link.burstValid), .burstCol(link.burstCol));
  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic checkCount(input int g, input int e);
    samples_checked++;
    if (g != e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic mrCmd(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, lmr_pkg::REG_CMD, {14'h0000, op, d, a});
  endtask
  // read a mode register, leaves the status word in rd
  task automatic mrRead(input logic [7:0] a);
    mrCmd(2'b00, a, 8'h00);
    repeat (3) @(posedge clk_sys);
    k = 0;
    do begin
      apb(1'b0, lmr_pkg::REG_STATUS, 32'h0000_0000);
      k++;
    end while (rd[lmr_pkg::STS_BUSY_BIT] !== 1'b0 && k < 8);
    check(rd[lmr_pkg::STS_BUSY_BIT], 1'b0);
  endtask
  task automatic burst(input logic [2:0] col);
    apb(1'b1, lmr_pkg::REG_BURST, {28'h000_0000, col, 1'b0});
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (link.burstValid !== 1'b1 && k < 10);
    got[15:12] = link.burstCol;
    for (int i = 1; i < 4; i++) begin
      @(posedge clk_sys);
      got[15 - 4 * i -: 4] = link.burstCol;
    end
  endtask
  task automatic precharge(input int n);
    @(posedge clk_sys);
    writeBurstAp <= 1'b1;
    @(posedge clk_sys);
    writeBurstAp <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (prechargeStart !== 1'b1 && k < 12);
    checkCount(k, n);
  endtask
  // issue init calibration and report whether it was accepted
  task automatic zqCal(input logic e);
    logic seen;
    seen = 1'b0;
    mrCmd(2'b10, 8'h00, 8'h00);
    repeat (4) begin
      @(posedge clk_sys);
      seen = seen | zqCalRun;
    end
    check(seen, e);
  endtask
  task automatic doReset();
    srst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    check({wrapControl, burstOrderSel, burstLengthSel, useFactoryTrim}, 6'h04);
  endtask
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    autoInitDone = 1'b0;
    zqSense = lmr_pkg::ZQ_RESISTOR_OK;
    writeBurstAp = 1'b0;
    doReset();
    mrRead(8'h00);
    check(rd[15:8], 8'h01);
    autoInitDone <= 1'b1;
    mrRead(8'h00);
    check(rd[15:8], 8'h00);
    check(rd[lmr_pkg::STS_INIT_DONE_BIT], 1'b1);
    $display("test reset and info done");
    for (int r = 0; r < 7; r++) begin
      mrCmd(2'b01, lmr_pkg::MA_BURST_WRITE_CONFIG, cfgTab[r]);
      repeat (2) @(posedge clk_sys);
      check(burstLengthSel, cfgTab[r][2:0]);
      check({wrapControl, burstOrderSel}, cfgTab[r][4:3]);
      burst(colTab[r]);
      check(got, expTab[r]);
      precharge(int'(cfgTab[r][7:5]) + 2);
    end
    $display("test burst table done");
    foreach (badTab[i]) begin
      mrCmd(2'b01, badTab[i][15:8], badTab[i][7:0]);
      apb(1'b0, lmr_pkg::REG_STATUS, 32'h0000_0000);
      check(rd[lmr_pkg::STS_REFUSED_BIT], 1'b1);
      check(burstLengthSel, lmr_pkg::BL_FOUR);
    end
    mrCmd(2'b01, lmr_pkg::MA_DEVICE_INFO_STATUS, 8'hFF);
    mrRead(8'h00);
    check(rd[15:8], 8'h00);
    strobe = rd[lmr_pkg::STS_STROBE_BIT];
    mrRead(8'h01);
    check(rd[15:8], 8'h00);
    check(rd[lmr_pkg::STS_STROBE_BIT], !strobe);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check(err, 1'b1);
    $display("test refusals done");
    zqCal(1'b1);
    mrRead(8'h00);
    check(rd[15:8], 8'h18);
    check(useFactoryTrim, 1'b0);
    zqSense <= lmr_pkg::ZQ_TO_GROUND;
    zqCal(1'b1);
    mrRead(8'h00);
    check({rd[15:8], useFactoryTrim}, 9'h021);
    zqSense <= lmr_pkg::ZQ_RESISTOR_OK;
    zqCal(1'b0);
    mrRead(8'h00);
    check(rd[15:8], 8'h10);
    doReset();
    zqSense <= lmr_pkg::ZQ_TO_SUPPLY;
    zqCal(1'b1);
    mrRead(8'h00);
    check({rd[15:8], useFactoryTrim}, 9'h011);
    $display("test self-test done");
    give_verdict();
  end
endmodule
